// ---- src/rsq_pkg.sv ----
// Constants, register map and carrier types for the rail sequencer.
// Assumes a single 125 MHz clock and a decoded serial-bus register port.
//
// Contract
// - Decay selected: downward code stops both FETs
// - Decay applies only to decreasing codes
// - Mask power ok until below new overvoltage
// - Upward during decay: wait ramp, then track
// - Aux one decodes tabulated steps, 1111 unused
// - Aux codes from bus; two/three 0.70V+0.05V
// - Option keeps aux one on through shutdown
// - Any member joins tree; status in registers
// - Per-output assertion delay within its range
// - Status output selectable as software output
// - Status output push-pull configuration supported
// - Enable from pin, prior power ok, software
// - Software enables or disables any rail directly; code ORs sw_en with the sequenced enable, so cannot disable it
// - Six group inputs; each member picks one
// - Inputs three/six as active-low sleep
// - Pin and power ok conditions combine
// - Per-rail delay before internal enable asserts
// - Mask power ok during voltage ramp
// - Hold enable until prior power ok asserts

package rsq_pkg;

  localparam int N_RAIL = 6;
  localparam int N_MEM  = 12;
  localparam int N_TREE = 4;
  localparam int N_GRP  = 6;

  // Timing
  localparam int CLK_HZ       = 125_000_000;
  localparam int CLK_NS       = 8;
  localparam int TICK_MS      = 1;
  localparam int MS_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int DVS_STEP_NS  = 6000;
  localparam int DVS_STEP_CYC = DVS_STEP_NS / CLK_NS;

  // Register offsets
  localparam logic [7:0] RAIL_CFG_BASE = 8'h00;
  localparam logic [7:0] SLP_CODE_BASE = 8'h08;
  localparam logic [7:0] SLP_ASGN_3    = 8'h10;
  localparam logic [7:0] SLP_ASGN_6    = 8'h11;
  localparam logic [7:0] SLP_MODE      = 8'h12;
  localparam logic [7:0] EN_CFG_BASE   = 8'h20;
  localparam logic [7:0] EN_SRC_BASE   = 8'h30;
  localparam logic [7:0] SW_EN_LO      = 8'h40;
  localparam logic [7:0] SW_EN_HI      = 8'h41;
  localparam logic [7:0] TREE_BASE     = 8'h50;
  localparam logic [7:0] TREE_DLY_BASE = 8'h58;
  localparam logic [7:0] GPO_MODE      = 8'h5c;
  localparam logic [7:0] GPO_PP        = 8'h5d;
  localparam logic [7:0] PG_STAT_LO    = 8'h60;
  localparam logic [7:0] PG_STAT_HI    = 8'h61;
  localparam logic [7:0] AUX_CODE_A    = 8'h9a;
  localparam logic [7:0] AUX_CODE_B    = 8'h9b;
  localparam logic [7:0] AUX_CODE_C    = 8'hae;

  // Field positions
  localparam int DECAY_BIT   = 7;
  localparam int EN_USE_PIN  = 3;
  localparam int EN_USE_PG   = 4;
  localparam int AUX_ONE_MEM = 6;
  localparam int SLP_PIN_3   = 2;
  localparam int SLP_PIN_6   = 5;

  // Tree delay limits in ms, element 0 is status output one
  localparam logic [3:0][6:0] PG_DLY_MIN = {7'h00, 7'h05, 7'h00, 7'h00};
  localparam logic [3:0][6:0] PG_DLY_MAX = {7'h64, 7'h64, 7'h64, 7'h0f};

  // Aux one output in mV, index = code; 1111 unused reads 0
  localparam logic [15:0][11:0] AUX1_MV_TBL = {
    12'h000, 12'hce4, 12'hbb8, 12'hb22, 12'ha28, 12'h9c4, 12'h960, 12'h8fc,
    12'h834, 12'h7d0, 12'h76c, 12'h708, 12'h6a4, 12'h640, 12'h5dc, 12'h546};
  localparam logic [11:0] AUXB_BASE_MV = 12'h2bc;
  localparam logic [11:0] AUXB_STEP_MV = 12'h032;
  localparam logic [11:0] AUXB_TOP_MV  = 12'h5dc;
  localparam logic [3:0]  AUX_CODE_TOP = 4'hf;

  typedef enum logic [3:0] {
    RS_IDLE  = 4'b0001,
    RS_SLEW  = 4'b0010,
    RS_DECAY = 4'b0100,
    RS_CATCH = 4'b1000
  } rsq_rail_st_e;

  typedef struct packed {
    logic       fet_en;
    logic [6:0] code;
  } rsq_rail_drive_s;

  typedef struct packed {
    rsq_rail_st_e    st;
    rsq_rail_drive_s drive;
    logic            pg_mask;
  } rsq_rail_s;

  typedef struct packed {
    logic [6:0] cnt;
    logic       done;
  } rsq_timer_s;

  typedef struct packed {
    logic [16:0]       tick_cnt;
    logic              tick;
    logic [9:0]        step_cnt;
    logic              step;
    logic [5:0][7:0]   rail_cfg;
    logic [5:0][6:0]   slp_code;
    logic [5:0]        slp_asgn3;
    logic [5:0]        slp_asgn6;
    logic [1:0]        slp_mode;
    logic [11:0][7:0]  en_cfg;
    logic [11:0][7:0]  en_src;
    logic [11:0]       sw_en;
    logic [3:0][11:0]  tree_mask;
    logic [3:0][6:0]   tree_dly;
    logic [3:0]        gpo_sw;
    logic [3:0]        gpo_lvl;
    logic [3:0]        gpo_pp;
    logic [2:0][3:0]   aux_code;
    logic [11:0]       rail_en;
    logic [11:0]       pg_stat;
    logic [3:0]        stat_o;
    logic [3:0]        stat_oe;
    logic [2:0][11:0]  aux_mv;
    logic [7:0]        rdata;
  } rsq_top_s;

endpackage

// ---- src/rsq_timer.sv ----
// Restartable delay timer counting millisecond ticks.
// Assumes tick is a one-cycle pulse from the top-level divider.
`timescale 1ns/1ps
`default_nettype none

module rsq_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Timing
  input  wire logic       tick,
  input  wire logic [6:0] limit,
  input  wire logic       cond,
  output var  logic       done
);

  rsq_pkg::rsq_timer_s q, d;

  always_comb begin
    d = q;
    if (!cond) begin
      d.cnt  = 7'h00;
      d.done = 1'b0;
    end else if (!q.done) begin
      if (q.cnt >= limit) begin
        d.done = 1'b1;
      end else if (tick) begin
        d.cnt = 7'(q.cnt + 7'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule

`default_nettype wire

// ---- src/rsq_rail.sv ----
// Voltage-code ramp and decay control for one switching rail.
// Assumes comparator inputs synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module rsq_rail (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Control
  input  wire logic                     en,
  input  wire logic [6:0]               tgt,
  input  wire logic                     decay,
  input  wire logic                     step,
  // Analog comparators
  input  wire logic                     below_ov,
  input  wire logic                     ramp_at_vout,
  // Outputs
  output rsq_pkg::rsq_rail_drive_s      drive,
  output var  logic                     pg_mask
);

  rsq_pkg::rsq_rail_s q, d;

  always_comb begin
    d = q;
    if (!en) begin
      d.st           = rsq_pkg::RS_IDLE;
      d.drive.fet_en = 1'b0;
      d.drive.code   = tgt;
      d.pg_mask      = 1'b0;
    end else begin
      case (q.st)
        rsq_pkg::RS_IDLE, rsq_pkg::RS_SLEW: begin
          d.drive.fet_en = 1'b1;
          if (tgt < q.drive.code && decay) begin
            d.drive.code   = tgt;
            d.drive.fet_en = 1'b0;
            d.pg_mask      = 1'b1;
            d.st           = rsq_pkg::RS_DECAY;
          end else if (tgt == q.drive.code) begin
            d.pg_mask = 1'b0;
            d.st      = rsq_pkg::RS_IDLE;
          end else begin
            d.pg_mask = 1'b1;
            d.st      = rsq_pkg::RS_SLEW;
            if (step && q.st == rsq_pkg::RS_SLEW) begin
              if (tgt > q.drive.code) begin
                d.drive.code = 7'(q.drive.code + 7'h01);
              end else begin
                d.drive.code = 7'(q.drive.code - 7'h01);
              end
            end
          end
        end
        rsq_pkg::RS_DECAY: begin
          d.drive.fet_en = 1'b0;
          d.pg_mask      = 1'b1;
          if (tgt > q.drive.code) begin
            d.st = rsq_pkg::RS_CATCH;
          end else if (tgt < q.drive.code) begin
            d.drive.code = tgt;
          end else if (below_ov) begin
            d.drive.fet_en = 1'b1;
            d.pg_mask      = 1'b0;
            d.st           = rsq_pkg::RS_IDLE;
          end
        end
        rsq_pkg::RS_CATCH: begin
          d.drive.fet_en = 1'b0;
          d.pg_mask      = 1'b1;
          if (ramp_at_vout || tgt == q.drive.code) begin
            d.drive.fet_en = 1'b1;
            d.st           = rsq_pkg::RS_SLEW;
          end else if (tgt < q.drive.code) begin
            d.drive.code = tgt;
            d.st         = rsq_pkg::RS_DECAY;
          end else if (step) begin
            d.drive.code = 7'(q.drive.code + 7'h01);
          end
        end
        default: begin
          d.st = rsq_pkg::RS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q    <= '0;
      q.st <= rsq_pkg::RS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign drive   = q.drive;
  assign pg_mask = q.pg_mask;

endmodule

`default_nettype wire

// ---- src/rsq_top.sv ----
// Rail enable sequencing, power-ok tree and status outputs.
// Assumes a decoded serial-bus register port and synchronous pins.
`timescale 1ns/1ps
`default_nettype none

module rsq_top #(
  parameter int MS_CYCLES = rsq_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          SYS_RST,
  // Register port
  input  wire logic                          REG_WE,
  input  wire logic                          REG_RE,
  input  wire logic [7:0]                    REG_ADDR,
  input  wire logic [7:0]                    REG_WDATA,
  output var  logic [7:0]                    REG_RDATA,
  // Group control inputs
  input  wire logic [5:0]                    GROUP_CONTROL_INPUT,
  // Supply and shutdown
  input  wire logic                          VSYS_OK,
  input  wire logic                          EMERG_SHDN,
  input  wire logic                          AUX_ONE_ALWAYS_ON,
  // Analog feedback
  input  wire logic [11:0]                   POWER_OK_RAW,
  input  wire logic [5:0]                    VOUT_BELOW_OV,
  input  wire logic [5:0]                    RAMP_AT_VOUT,
  // Rail drive
  output var  logic [11:0]                   RAIL_EN,
  output rsq_pkg::rsq_rail_drive_s [5:0]     RAIL_DRIVE,
  output var  logic [2:0][11:0]              AUX_MV,
  // Status outputs
  output var  logic [3:0]                    STATUS_O,
  output var  logic [3:0]                    STATUS_OE
);

  rsq_pkg::rsq_top_s q, d;

  logic [11:0] en_qual;
  logic [11:0] en_done;
  logic [3:0]  tree_ok;
  logic [3:0]  tree_done;
  logic [5:0]  pg_mask;
  logic [5:0]  grp_pin;
  logic [5:0]  sleeping;

  function automatic logic [6:0] clamp_dly(input logic [6:0] v, input int k);
    logic [6:0] r;
    r = v;
    if (v < rsq_pkg::PG_DLY_MIN[k]) begin
      r = rsq_pkg::PG_DLY_MIN[k];
    end else if (v > rsq_pkg::PG_DLY_MAX[k]) begin
      r = rsq_pkg::PG_DLY_MAX[k];
    end
    return r;
  endfunction

  function automatic logic [11:0] auxb_mv(input logic [3:0] c);
    logic [11:0] r;
    r = 12'(rsq_pkg::AUXB_BASE_MV + rsq_pkg::AUXB_STEP_MV * 12'(c));
    if (c == rsq_pkg::AUX_CODE_TOP) begin
      r = rsq_pkg::AUXB_TOP_MV;
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] base, input int i);
    return REG_ADDR == 8'(base + 8'(i));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Group pins, sleep and enable qualification

  always_comb begin
    grp_pin = GROUP_CONTROL_INPUT;
    if (q.slp_mode[0]) begin
      grp_pin[rsq_pkg::SLP_PIN_3] = 1'b1;
    end
    if (q.slp_mode[1]) begin
      grp_pin[rsq_pkg::SLP_PIN_6] = 1'b1;
    end
    for (int i = 0; i < rsq_pkg::N_RAIL; i++) begin
      sleeping[i] = (q.slp_mode[0] && !GROUP_CONTROL_INPUT[rsq_pkg::SLP_PIN_3]
                     && q.slp_asgn3[i])
                 || (q.slp_mode[1] && !GROUP_CONTROL_INPUT[rsq_pkg::SLP_PIN_6]
                     && q.slp_asgn6[i]);
    end
  end

  always_comb begin
    for (int m = 0; m < rsq_pkg::N_MEM; m++) begin
      logic use_pin;
      logic use_pg;
      logic pin_ok;
      logic pg_ok;
      use_pin = q.en_cfg[m][rsq_pkg::EN_USE_PIN];
      use_pg  = q.en_cfg[m][rsq_pkg::EN_USE_PG];
      pin_ok  = !use_pin || grp_pin[q.en_cfg[m][2:0]];
      pg_ok   = !use_pg || q.pg_stat[q.en_src[m][3:0]];
      en_qual[m] = (use_pin || use_pg) && pin_ok && pg_ok && !EMERG_SHDN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers and switching rails

  for (genvar m = 0; m < rsq_pkg::N_MEM; m++) begin : g_en
    rsq_timer u_en_dly (
      .clk   (CLK),
      .rst   (SYS_RST),
      .tick  (q.tick),
      .limit ({3'h0, q.en_src[m][7:4]}),
      .cond  (en_qual[m]),
      .done  (en_done[m])
    );
  end

  for (genvar k = 0; k < rsq_pkg::N_TREE; k++) begin : g_tree
    assign tree_ok[k] = (q.tree_mask[k] != 12'h000)
                     && ((q.pg_stat & q.tree_mask[k]) == q.tree_mask[k]);
    rsq_timer u_pg_dly (
      .clk   (CLK),
      .rst   (SYS_RST),
      .tick  (q.tick),
      .limit (clamp_dly(q.tree_dly[k], k)),
      .cond  (tree_ok[k]),
      .done  (tree_done[k])
    );
  end

  for (genvar i = 0; i < rsq_pkg::N_RAIL; i++) begin : g_rail
    rsq_rail u_rail (
      .clk          (CLK),
      .rst          (SYS_RST),
      .en           (q.rail_en[i]),
      .tgt          (sleeping[i] ? q.slp_code[i] : q.rail_cfg[i][6:0]),
      .decay        (q.rail_cfg[i][rsq_pkg::DECAY_BIT]),
      .step         (q.step),
      .below_ov     (VOUT_BELOW_OV[i]),
      .ramp_at_vout (RAMP_AT_VOUT[i]),
      .drive        (RAIL_DRIVE[i]),
      .pg_mask      (pg_mask[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;

    // Millisecond tick and ramp step dividers
    d.tick = 1'b0;
    d.step = 1'b0;
    if (q.tick_cnt == 17'(MS_CYCLES - 1)) begin
      d.tick_cnt = 17'h0_0000;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = 17'(q.tick_cnt + 17'h0_0001);
    end
    if (q.step_cnt == 10'(rsq_pkg::DVS_STEP_CYC - 1)) begin
      d.step_cnt = 10'h000;
      d.step     = 1'b1;
    end else begin
      d.step_cnt = 10'(q.step_cnt + 10'h001);
    end

    // Register writes
    if (REG_WE) begin
      for (int i = 0; i < rsq_pkg::N_RAIL; i++) begin
        if (hit(rsq_pkg::RAIL_CFG_BASE, i)) d.rail_cfg[i] = REG_WDATA;
        if (hit(rsq_pkg::SLP_CODE_BASE, i)) d.slp_code[i] = REG_WDATA[6:0];
      end
      for (int m = 0; m < rsq_pkg::N_MEM; m++) begin
        if (hit(rsq_pkg::EN_CFG_BASE, m)) d.en_cfg[m] = REG_WDATA;
        if (hit(rsq_pkg::EN_SRC_BASE, m)) d.en_src[m] = REG_WDATA;
      end
      for (int k = 0; k < rsq_pkg::N_TREE; k++) begin
        if (hit(rsq_pkg::TREE_BASE, 2 * k)) d.tree_mask[k][7:0] = REG_WDATA;
        if (hit(rsq_pkg::TREE_BASE, 2 * k + 1)) d.tree_mask[k][11:8] = REG_WDATA[3:0];
        if (hit(rsq_pkg::TREE_DLY_BASE, k)) d.tree_dly[k] = REG_WDATA[6:0];
      end
      case (REG_ADDR)
        rsq_pkg::SLP_ASGN_3: d.slp_asgn3 = REG_WDATA[5:0];
        rsq_pkg::SLP_ASGN_6: d.slp_asgn6 = REG_WDATA[5:0];
        rsq_pkg::SLP_MODE:   d.slp_mode  = REG_WDATA[1:0];
        rsq_pkg::SW_EN_LO:   d.sw_en[7:0]  = REG_WDATA;
        rsq_pkg::SW_EN_HI:   d.sw_en[11:8] = REG_WDATA[3:0];
        rsq_pkg::GPO_MODE: begin
          d.gpo_sw  = REG_WDATA[3:0];
          d.gpo_lvl = REG_WDATA[7:4];
        end
        rsq_pkg::GPO_PP:     d.gpo_pp      = REG_WDATA[3:0];
        rsq_pkg::AUX_CODE_A: d.aux_code[0] = REG_WDATA[3:0];
        rsq_pkg::AUX_CODE_B: d.aux_code[1] = REG_WDATA[3:0];
        rsq_pkg::AUX_CODE_C: d.aux_code[2] = REG_WDATA[3:0];
        default: ;
      endcase
    end

    // Rail enables
    for (int m = 0; m < rsq_pkg::N_MEM; m++) begin
      d.rail_en[m] = (q.sw_en[m] || en_done[m]) && !EMERG_SHDN;
    end
    if (AUX_ONE_ALWAYS_ON && VSYS_OK) begin
      d.rail_en[rsq_pkg::AUX_ONE_MEM] = 1'b1;
    end

    // Power ok per member, masked during ramp or decay
    for (int m = 0; m < rsq_pkg::N_MEM; m++) begin
      d.pg_stat[m] = POWER_OK_RAW[m] && q.rail_en[m];
    end
    for (int i = 0; i < rsq_pkg::N_RAIL; i++) begin
      if (pg_mask[i]) d.pg_stat[i] = 1'b0;
    end

    // Status output pins
    for (int k = 0; k < rsq_pkg::N_TREE; k++) begin
      logic lvl;
      lvl = q.gpo_sw[k] ? q.gpo_lvl[k] : (tree_done[k] && !EMERG_SHDN);
      d.stat_o[k]  = q.gpo_pp[k] ? lvl : 1'b0;
      d.stat_oe[k] = q.gpo_pp[k] ? 1'b1 : !lvl;
    end

    // Aux regulator levels
    d.aux_mv[0] = rsq_pkg::AUX1_MV_TBL[q.aux_code[0]];
    d.aux_mv[1] = auxb_mv(q.aux_code[1]);
    d.aux_mv[2] = auxb_mv(q.aux_code[2]);

    // Register reads
    d.rdata = 8'h00;
    if (REG_RE) begin
      for (int i = 0; i < rsq_pkg::N_RAIL; i++) begin
        if (hit(rsq_pkg::RAIL_CFG_BASE, i)) d.rdata = q.rail_cfg[i];
        if (hit(rsq_pkg::SLP_CODE_BASE, i)) d.rdata = {1'b0, q.slp_code[i]};
      end
      for (int m = 0; m < rsq_pkg::N_MEM; m++) begin
        if (hit(rsq_pkg::EN_CFG_BASE, m)) d.rdata = q.en_cfg[m];
        if (hit(rsq_pkg::EN_SRC_BASE, m)) d.rdata = q.en_src[m];
      end
      for (int k = 0; k < rsq_pkg::N_TREE; k++) begin
        if (hit(rsq_pkg::TREE_BASE, 2 * k)) d.rdata = q.tree_mask[k][7:0];
        if (hit(rsq_pkg::TREE_BASE, 2 * k + 1)) d.rdata = {4'h0, q.tree_mask[k][11:8]};
        if (hit(rsq_pkg::TREE_DLY_BASE, k)) d.rdata = {1'b0, q.tree_dly[k]};
      end
      case (REG_ADDR)
        rsq_pkg::SLP_ASGN_3: d.rdata = {2'h0, q.slp_asgn3};
        rsq_pkg::SLP_ASGN_6: d.rdata = {2'h0, q.slp_asgn6};
        rsq_pkg::SLP_MODE:   d.rdata = {6'h00, q.slp_mode};
        rsq_pkg::SW_EN_LO:   d.rdata = q.sw_en[7:0];
        rsq_pkg::SW_EN_HI:   d.rdata = {4'h0, q.sw_en[11:8]};
        rsq_pkg::GPO_MODE:   d.rdata = {q.gpo_lvl, q.gpo_sw};
        rsq_pkg::GPO_PP:     d.rdata = {4'h0, q.gpo_pp};
        rsq_pkg::PG_STAT_LO: d.rdata = q.pg_stat[7:0];
        rsq_pkg::PG_STAT_HI: d.rdata = {4'h0, q.pg_stat[11:8]};
        rsq_pkg::AUX_CODE_A: d.rdata = {4'h0, q.aux_code[0]};
        rsq_pkg::AUX_CODE_B: d.rdata = {4'h0, q.aux_code[1]};
        rsq_pkg::AUX_CODE_C: d.rdata = {4'h0, q.aux_code[2]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q         <= '0;
      q.stat_oe <= 4'hf;
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign RAIL_EN   = q.rail_en;
  assign AUX_MV    = q.aux_mv;
  assign STATUS_O  = q.stat_o;
  assign STATUS_OE = q.stat_oe;

endmodule

`default_nettype wire

// ---- testbench/rsq_asserts.sv ----
// Concurrent checks on the rail sequencer top-level ports.
// Assumes it is bound into rsq_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module rsq_asserts #(
  parameter int MS_CYCLES = rsq_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic             CLK,
  input wire logic             SYS_RST,
  // Register port
  input wire logic             REG_WE,
  input wire logic             REG_RE,
  input wire logic [7:0]       REG_ADDR,
  input wire logic [7:0]       REG_WDATA,
  input wire logic [7:0]       REG_RDATA,
  // Supply and shutdown
  input wire logic             VSYS_OK,
  input wire logic             EMERG_SHDN,
  input wire logic             AUX_ONE_ALWAYS_ON,
  // Outputs
  input wire logic [11:0]      RAIL_EN,
  input wire rsq_pkg::rsq_rail_drive_s [5:0] RAIL_DRIVE,
  input wire logic [2:0][11:0] AUX_MV,
  input wire logic [3:0]       STATUS_O,
  input wire logic [3:0]       STATUS_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_aux_b_wr;
    REG_WE && REG_ADDR == rsq_pkg::AUX_CODE_B && REG_WDATA[3:0] != 4'hf;
  endsequence
  sequence s_aux_b_top;
    REG_WE && REG_ADDR == rsq_pkg::AUX_CODE_B && REG_WDATA[3:0] == 4'hf;
  endsequence

  ////////////////////////////////////////
  rd_idle_a: assert property (!$past(REG_RE) |-> REG_RDATA == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property (REG_RE && REG_ADDR == 8'hf0 |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  aux_b_code_a: assert property (s_aux_b_wr |-> ##2
    AUX_MV[1] == 12'h2bc + 12'h032 * {8'h00, $past(REG_WDATA[3:0], 2)})
    else $error("aux two level wrong");
  aux_b_top_a: assert property (s_aux_b_top |-> ##2 AUX_MV[1] == 12'h5dc)
    else $error("aux two top level wrong");
  aux_one_off_a: assert property (REG_WE && REG_ADDR == rsq_pkg::AUX_CODE_A
    && REG_WDATA[3:0] == 4'hf |-> ##2 AUX_MV[0] == 12'h000)
    else $error("aux one unused code not off");
  decay_down_a: assert property ($fell(RAIL_DRIVE[0].fet_en) && $past(RAIL_EN[0])
    && RAIL_EN[0] |-> RAIL_DRIVE[0].code < $past(RAIL_DRIVE[0].code))
    else $error("fets stopped on upward change");
  slew_step_a: assert property (RAIL_DRIVE[0].fet_en && $past(RAIL_DRIVE[0].fet_en)
    && RAIL_EN[0] && $past(RAIL_EN[0]) |->
    RAIL_DRIVE[0].code - $past(RAIL_DRIVE[0].code) inside {7'h00, 7'h01, 7'h7f})
    else $error("code jumped while switching");
  shdn_off_a: assert property (EMERG_SHDN |=> (RAIL_EN & 12'hfbf) == 12'h000)
    else $error("enable survived shutdown");
  aux_on_a: assert property (EMERG_SHDN && AUX_ONE_ALWAYS_ON && VSYS_OK && RAIL_EN[6]
    |=> RAIL_EN[6])
    else $error("always-on aux dropped");
  reset_out_a: assert property ($fell(SYS_RST) |-> RAIL_EN == 12'h000
    && STATUS_OE == 4'hf && STATUS_O == 4'h0)
    else $error("outputs not idle after reset");
endmodule

bind rsq_top rsq_asserts #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .CLK, .SYS_RST, .REG_WE, .REG_RE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
  .VSYS_OK, .EMERG_SHDN, .AUX_ONE_ALWAYS_ON, .RAIL_EN, .RAIL_DRIVE,
  .AUX_MV, .STATUS_O, .STATUS_OE);

`default_nettype wire

// ---- testbench/rsq_analog_model.sv ----
// Analog side of the rails: output level, comparators, power ok.
// Assumes the sequencer's registered enables and rail drive.
`timescale 1ns/1ps
`default_nettype none

module rsq_analog_model (
  // Clock
  input  wire logic                          CLK,
  // From the sequencer
  input  wire logic [11:0]                   RAIL_EN,
  input  wire rsq_pkg::rsq_rail_drive_s [5:0] RAIL_DRIVE,
  // To the sequencer
  output var  logic [11:0]                   POWER_OK_RAW,
  output var  logic [5:0]                    VOUT_BELOW_OV,
  output var  logic [5:0]                    RAMP_AT_VOUT
);
  logic [5:0][6:0]  vout_q;
  logic [3:0][11:0] en_dly_q;
  logic [5:0]       div_q = 6'h00;

  always_ff @(posedge CLK) begin
    en_dly_q <= {en_dly_q[2:0], RAIL_EN};
    div_q    <= div_q + 6'h01;
    for (int i = 0; i < 6; i++) begin
      if (!RAIL_EN[i]) begin
        vout_q[i] <= 7'h00;
      end else if (RAIL_DRIVE[i].fet_en) begin
        vout_q[i] <= RAIL_DRIVE[i].code;
      end else if (div_q == 6'h00 && vout_q[i] != 7'h00) begin
        vout_q[i] <= vout_q[i] - 7'h01;   // Free fall, FETs idle
      end
    end
  end

  assign POWER_OK_RAW = en_dly_q[3] & RAIL_EN;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      VOUT_BELOW_OV[i] = vout_q[i] <= RAIL_DRIVE[i].code;
      RAMP_AT_VOUT[i]  = RAIL_DRIVE[i].code >= vout_q[i];
    end
  end
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the rail sequencer top level.
// Assumes the analog model on the rail feedback, 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0, sys_rst, reg_we, reg_re, vsys_ok, shdn, aon;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [5:0]  gci, below_ov, at_vout;
  logic [11:0] pok, rail_en;
  logic [3:0]  stat_o, stat_oe;
  logic [2:0][11:0] aux_mv;
  rsq_pkg::rsq_rail_drive_s [5:0] drive;
  logic [2:0][3:0]  a1_code = {4'hf, 4'he, 4'h0};
  logic [2:0][11:0] a1_mv = {12'h000, 12'hce4, 12'h546};
  int err_count = 0;
  int checks_done = 0;

  rsq_top #(.MS_CYCLES(10)) dut_u (
    .CLK(clk), .SYS_RST(sys_rst), .REG_WE(reg_we), .REG_RE(reg_re),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .GROUP_CONTROL_INPUT(gci), .VSYS_OK(vsys_ok), .EMERG_SHDN(shdn),
    .AUX_ONE_ALWAYS_ON(aon), .POWER_OK_RAW(pok), .VOUT_BELOW_OV(below_ov),
    .RAMP_AT_VOUT(at_vout), .RAIL_EN(rail_en), .RAIL_DRIVE(drive),
    .AUX_MV(aux_mv), .STATUS_O(stat_o), .STATUS_OE(stat_oe));
  rsq_analog_model model_u (
    .CLK(clk), .RAIL_EN(rail_en), .RAIL_DRIVE(drive), .POWER_OK_RAW(pok),
    .VOUT_BELOW_OV(below_ov), .RAMP_AT_VOUT(at_vout));

  ////////////////////////////////////////
  initial forever #4 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    {sys_rst, reg_we, reg_re, reg_addr, reg_wdata} = {1'b1, 18'h0_0000};
    {vsys_ok, shdn, aon, gci} = {3'b100, 6'h04};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tick(2);
    chk(aux_mv[0], 12'h546);
    chk(aux_mv[1], 12'h2bc);
    chk(12'(stat_oe), 12'h00f);
    for (int i = 0; i < 3; i++) begin
      wr(rsq_pkg::AUX_CODE_A, {4'h0, a1_code[i]});
      tick(2);
      chk(aux_mv[0], a1_mv[i]);
    end
    wr(rsq_pkg::AUX_CODE_B, 8'h03);
    wr(rsq_pkg::AUX_CODE_C, 8'h03);
    tick(2);
    chk(aux_mv[2], 12'h352);
    wr(rsq_pkg::AUX_CODE_B, 8'h0f);
    rd(rsq_pkg::AUX_CODE_B);
    chk(aux_mv[1], 12'h5dc);
    chk(12'(rd_val), 12'h00f);
    rd(8'hf0);
    chk(12'(rd_val), 12'h000);
    wr(rsq_pkg::PG_STAT_LO, 8'hff);
    rd(rsq_pkg::PG_STAT_LO);
    chk(12'(rd_val), 12'h000);
    // Software enable, then decay down, slew up, catch up
    wr(rsq_pkg::RAIL_CFG_BASE, 8'h30);
    wr(rsq_pkg::SW_EN_LO, 8'h01);
    tick(2);
    chk(rail_en, 12'h001);
    tick(8);
    rd(rsq_pkg::PG_STAT_LO);
    chk(12'(rd_val), 12'h001);
    chk(12'(drive[0]), 12'h0b0);
    wr(rsq_pkg::RAIL_CFG_BASE, 8'ha0);
    tick(1);
    rd(rsq_pkg::PG_STAT_LO);
    chk(12'(drive[0]), 12'h020);
    chk(12'(rd_val[0]), 12'h000);
    tick(1300);
    rd(rsq_pkg::PG_STAT_LO);
    chk(12'(rd_val[0]), 12'h001);
    wr(rsq_pkg::RAIL_CFG_BASE, 8'ha2);
    tick(1);
    rd(rsq_pkg::PG_STAT_LO);
    chk(12'(drive[0].fet_en), 12'h001);
    chk(12'(rd_val[0]), 12'h000);
    tick(1600);
    chk(12'(drive[0]), 12'h0a2);
    wr(rsq_pkg::RAIL_CFG_BASE, 8'h90);
    tick(200);
    wr(rsq_pkg::RAIL_CFG_BASE, 8'h98);
    tick(2);
    chk(12'(drive[0].fet_en), 12'h000);
    tick(3000);
    chk(12'(drive[0].fet_en), 12'h001);
    // Member 1 on pin 5 and power ok of member 3; member 3 on pin 6, 2 ms
    wr(rsq_pkg::EN_CFG_BASE + 8'h01, 8'h1c);
    wr(rsq_pkg::EN_SRC_BASE + 8'h01, 8'h03);
    wr(rsq_pkg::EN_CFG_BASE + 8'h03, 8'h0d);
    wr(rsq_pkg::EN_SRC_BASE + 8'h03, 8'h20);
    gci[4] <= 1'b1;
    tick(20);
    chk(12'(rail_en[1]), 12'h000);
    gci[5] <= 1'b1;
    tick(8);
    chk(12'(rail_en[3]), 12'h000);
    tick(32);
    chk(12'(rail_en[3]), 12'h001);
    tick(12);
    chk(12'(rail_en[1]), 12'h001);
    // Tree one on members 1 and 3, delay clamped to 15 ms
    wr(rsq_pkg::TREE_DLY_BASE, 8'h14);
    wr(rsq_pkg::TREE_BASE, 8'h0a);
    tick(120);
    chk(12'(stat_oe[0]), 12'h001);
    tick(60);
    chk(12'(stat_oe[0]), 12'h000);
    gci[4] <= 1'b0;
    tick(8);
    chk(12'(stat_oe[0]), 12'h001);
    wr(rsq_pkg::GPO_PP, 8'h01);
    tick(3);
    chk(12'({stat_o[0], stat_oe[0]}), 12'h001);
    wr(rsq_pkg::GPO_MODE, 8'h11);
    tick(3);
    chk(12'({stat_o[0], stat_oe[0]}), 12'h003);
    wr(rsq_pkg::GPO_PP, 8'h00);
    tick(3);
    chk(12'(stat_oe[0]), 12'h000);
    wr(rsq_pkg::GPO_MODE, 8'h01);
    tick(3);
    chk(12'(stat_oe[0]), 12'h001);
    // Sleep on pin three
    wr(rsq_pkg::SLP_CODE_BASE, 8'h08);
    wr(rsq_pkg::SLP_ASGN_3, 8'h01);
    wr(rsq_pkg::SLP_MODE, 8'h01);
    gci[2] <= 1'b0;
    tick(4);
    chk(12'(drive[0].code), 12'h008);
    // Shutdown with always-on aux one
    wr(rsq_pkg::SW_EN_LO, 8'h41);
    {aon, shdn} <= 2'b11;
    tick(3);
    chk(rail_en, 12'h040);
    aon <= 1'b0;
    tick(3);
    chk(rail_en, 12'h000);
    {shdn, sys_rst} <= 2'b01;
    tick(2);
    sys_rst <= 1'b0;
    rd(rsq_pkg::AUX_CODE_B);
    chk(12'(rd_val), 12'h000);
    chk(rail_en, 12'h000);
    conclude();
  end
endmodule

`default_nettype wire
